// [rtl/scl_pkg.sv]
// scl_pkg: shared constants and types for the command legality checker.
// assumes a four-bank device with one controller driving command pins.
package scl_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int NUM_BANKS      = 4;
    localparam int BANK_W         = 2;
    localparam int CNT_W          = 8;
    localparam int BURST_BOUNDARY = 4;

    // ------------------------------------------------------------
    // timing counts (cycles at 40 MHz, defaults)
    // ------------------------------------------------------------
    localparam logic [CNT_W-1:0] MODE_SET_DELAY_CYC      = 8'h02;
    localparam logic [CNT_W-1:0] REFRESH_CYCLE_TIME_CYC  = 8'h05;
    localparam logic [CNT_W-1:0] ACT_TO_COL_DELAY_CYC    = 8'h01;
    localparam logic [CNT_W-1:0] WRITE_TO_READ_DELAY_CYC = 8'h01;
    localparam logic [CNT_W-1:0] WRITE_RECOVERY_CYC      = 8'h02;
    localparam logic [CNT_W-1:0] PRECHARGE_CYC           = 8'h01;
    localparam logic [CNT_W-1:0] READ_BURST_CYC          = 8'h04;

    // ------------------------------------------------------------
    // decoded commands and per-bank states
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        SCL_DESELECT, SCL_NOP, SCL_READ, SCL_WRITE, SCL_ACTIVATE,
        SCL_PRECHARGE, SCL_REFRESH, SCL_MODE_SET
    } scl_cmd_t;

    typedef enum logic [2:0] {
        SCL_IDLE, SCL_ACTIVATING, SCL_ACTIVE, SCL_READING, SCL_WRITING,
        SCL_PRECHARGING
    } scl_bank_t;

    typedef enum logic [1:0] {
        SCL_G_NORMAL, SCL_G_MODE_SET, SCL_G_REFRESH
    } scl_glob_t;

endpackage

// [rtl/scl_cmd_if.sv]
// scl_cmd_if: decoded command carried from decoder to bank tracker.
// assumes one clock domain; fields are registered by the decoder.
`timescale 1ns/1ps
interface scl_cmd_if;
    import scl_pkg::*;
    scl_cmd_t          cmd;
    logic [BANK_W-1:0] bank;
    logic              a10;
    logic              valid;
    modport src (output cmd, bank, a10, valid);
    modport dst (input  cmd, bank, a10, valid);
endinterface

// [rtl/scl_decode.sv]
// scl_decode: samples command pins and decodes the command.
// assumes pins are synchronous to i_mclk (controller on the same clock).
`timescale 1ns/1ps
module scl_decode
    import scl_pkg::*;
(
    // clock and reset
    input  wire logic              i_mclk,
    input  wire logic              i_rst,
    // command pins
    input  wire logic              i_cs_n,
    input  wire logic              i_ras_n,
    input  wire logic              i_cas_n,
    input  wire logic              i_we_n,
    input  wire logic [BANK_W-1:0] i_bank,
    input  wire logic              i_a10,
    // decoded output
    scl_cmd_if.src                 o_cmd
);

    scl_cmd_t cmd_next;

    always_comb begin
        cmd_next = SCL_NOP;
        if (i_cs_n) begin
            cmd_next = SCL_DESELECT;
        end else begin
            case ({i_ras_n, i_cas_n, i_we_n})
                3'h7: cmd_next = SCL_NOP;
                3'h5: cmd_next = SCL_READ;
                3'h4: cmd_next = SCL_WRITE;
                3'h3: cmd_next = SCL_ACTIVATE;
                3'h2: cmd_next = SCL_PRECHARGE;
                3'h1: cmd_next = SCL_REFRESH;
                3'h0: cmd_next = SCL_MODE_SET;
                default: cmd_next = SCL_NOP;
            endcase
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_cmd.cmd   <= SCL_DESELECT;
            o_cmd.bank  <= '0;
            o_cmd.a10   <= 1'b0;
            o_cmd.valid <= 1'b0;
        end else begin
            o_cmd.cmd   <= cmd_next;
            o_cmd.bank  <= i_bank;
            o_cmd.a10   <= i_a10;
            o_cmd.valid <= 1'b1;
        end
    end

endmodule

// [rtl/scl_legality.sv]
// scl_legality: per-bank command legality and return-to-idle tracking.
// assumes the controller is on i_mclk; pins are sampled without synchronisers.
// How it works
// - after mode set only idle commands; idle after delay
// - busy-bank command judged by addressed bank
// - read burst interruption only on four-beat boundary; write bursts end with write recovery
// - column during activate allowed if latency covers
// - read in write recovery always flagged; legal once bank is active again
// - decode pins; cs high deselect; others ignored
// - during refresh only idle commands; idle after
`timescale 1ns/1ps
module scl_legality
    import scl_pkg::*;
#(
    parameter logic [CNT_W-1:0] P_MODE_SET_DELAY   = MODE_SET_DELAY_CYC,
    parameter logic [CNT_W-1:0] P_REFRESH_CYCLE    = REFRESH_CYCLE_TIME_CYC,
    parameter logic [CNT_W-1:0] P_ACT_TO_COL       = ACT_TO_COL_DELAY_CYC,
    parameter logic [CNT_W-1:0] P_WRITE_TO_READ    = WRITE_TO_READ_DELAY_CYC
)
(
    // clock and reset
    input  wire logic                 i_mclk,
    input  wire logic                 i_rst,
    // command pins from the controller
    input  wire logic                 i_cs_n,
    input  wire logic                 i_ras_n,
    input  wire logic                 i_cas_n,
    input  wire logic                 i_we_n,
    input  wire logic [BANK_W-1:0]    i_bank,
    input  wire logic                 i_a10,
    // mode configuration
    input  wire logic [CNT_W-1:0]     i_additive_latency,
    // status
    output logic                      o_illegal,
    output logic [NUM_BANKS-1:0]      o_bank_idle,
    output logic                      o_all_idle,
    output logic                      o_mode_setting,
    output logic                      o_refreshing
);

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    scl_cmd_if cmd_bus ();

    scl_decode scl_decode_inst (
        .i_mclk  (i_mclk),
        .i_rst   (i_rst),
        .i_cs_n  (i_cs_n),
        .i_ras_n (i_ras_n),
        .i_cas_n (i_cas_n),
        .i_we_n  (i_we_n),
        .i_bank  (i_bank),
        .i_a10   (i_a10),
        .o_cmd   (cmd_bus.src)
    );

    scl_cmd_t          cmd;
    logic [BANK_W-1:0] bsel;
    assign cmd  = cmd_bus.valid ? cmd_bus.cmd : SCL_DESELECT;
    assign bsel = cmd_bus.bank;

    // ------------------------------------------------------------
    // per-bank state
    // ------------------------------------------------------------
    scl_bank_t        bank_reg [NUM_BANKS];
    logic [CNT_W-1:0] bcnt_reg [NUM_BANKS];
    logic [CNT_W-1:0] wtr_reg  [NUM_BANKS];
    logic [1:0]       beat_reg [NUM_BANKS];
    logic [NUM_BANKS-1:0] idle_vec;
    logic [NUM_BANKS-1:0] bad_vec;

    scl_glob_t        glob_reg;
    logic [CNT_W-1:0] gcnt_reg;
    logic             all_idle;

    assign all_idle = &idle_vec;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_BANKS; gi++) begin : g_bank
            logic hit;
            logic bad;
            logic al_covers;
            assign hit       = (bsel == BANK_W'(gi));
            assign al_covers = (i_additive_latency >= P_ACT_TO_COL);
            assign idle_vec[gi] = (bank_reg[gi] == SCL_IDLE);

            // a command to another bank is judged only by that bank
            always_comb begin
                bad = 1'b0;
                if (hit && glob_reg == SCL_G_NORMAL) begin
                    case (bank_reg[gi])
                        SCL_IDLE:
                            bad = (cmd == SCL_READ) || (cmd == SCL_WRITE);
                        SCL_ACTIVATING:
                            bad = (cmd == SCL_ACTIVATE) || (cmd == SCL_PRECHARGE)
                                || (((cmd == SCL_READ) || (cmd == SCL_WRITE))
                                    && !al_covers);
                        SCL_ACTIVE:
                            bad = (cmd == SCL_ACTIVATE);
                        SCL_READING, SCL_WRITING:
                            bad = (cmd == SCL_ACTIVATE)
                                || (((cmd == SCL_READ) || (cmd == SCL_WRITE))
                                    && beat_reg[gi] != 2'h0)
                                || ((cmd == SCL_READ) && bank_reg[gi] == SCL_WRITING
                                    && wtr_reg[gi] != '0);
                        SCL_PRECHARGING:
                            bad = (cmd == SCL_READ) || (cmd == SCL_WRITE)
                                || (cmd == SCL_ACTIVATE);
                        default: bad = 1'b0;
                    endcase
                end
            end
            assign bad_vec[gi] = bad;

            always_ff @(posedge i_mclk or posedge i_rst) begin
                if (i_rst) begin
                    bank_reg[gi] <= SCL_IDLE;
                    bcnt_reg[gi] <= '0;
                    wtr_reg[gi]  <= '0;
                    beat_reg[gi] <= 2'h0;
                end else begin
                    // beat counter wraps every four-beat boundary
                    beat_reg[gi] <= beat_reg[gi] + 2'h1;
                    if (wtr_reg[gi] != '0) begin
                        wtr_reg[gi] <= wtr_reg[gi] - 8'h01;
                    end
                    if (bcnt_reg[gi] != '0) begin
                        bcnt_reg[gi] <= bcnt_reg[gi] - 8'h01;
                    end
                    if (glob_reg != SCL_G_NORMAL) begin
                        bank_reg[gi] <= SCL_IDLE;
                    end else if (!bad_vec[gi] && hit && cmd == SCL_ACTIVATE) begin
                        bank_reg[gi] <= SCL_ACTIVATING;
                        bcnt_reg[gi] <= P_ACT_TO_COL;
                    end else if (!bad_vec[gi] && hit
                                 && (cmd == SCL_READ || cmd == SCL_WRITE)) begin
                        bank_reg[gi] <= (cmd == SCL_READ) ? SCL_READING : SCL_WRITING;
                        bcnt_reg[gi] <= (cmd == SCL_READ) ? READ_BURST_CYC
                                                          : WRITE_RECOVERY_CYC;
                        beat_reg[gi] <= 2'h1;
                        if (cmd == SCL_WRITE) begin
                            wtr_reg[gi] <= P_WRITE_TO_READ;
                        end
                    end else if (cmd == SCL_PRECHARGE && (hit || cmd_bus.a10)
                                 && !bad_vec[gi] && bank_reg[gi] != SCL_IDLE) begin
                        bank_reg[gi] <= SCL_PRECHARGING;
                        bcnt_reg[gi] <= PRECHARGE_CYC;
                    end else if (bcnt_reg[gi] == 8'h01 || bcnt_reg[gi] == '0) begin
                        case (bank_reg[gi])
                            SCL_ACTIVATING, SCL_READING, SCL_WRITING:
                                bank_reg[gi] <= SCL_ACTIVE;
                            SCL_PRECHARGING:
                                bank_reg[gi] <= SCL_IDLE;
                            default: bank_reg[gi] <= bank_reg[gi];
                        endcase
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // global mode-set and refresh states
    // ------------------------------------------------------------
    logic glob_bad;

    always_comb begin
        glob_bad = 1'b0;
        case (glob_reg)
            // only deselect or no-operation while mode set or refresh runs
            SCL_G_MODE_SET, SCL_G_REFRESH:
                glob_bad = (cmd != SCL_DESELECT) && (cmd != SCL_NOP);
            default:
                glob_bad = ((cmd == SCL_REFRESH) || (cmd == SCL_MODE_SET))
                           && !all_idle;
        endcase
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            glob_reg <= SCL_G_NORMAL;
            gcnt_reg <= '0;
        end else begin
            case (glob_reg)
                SCL_G_NORMAL: begin
                    if (cmd == SCL_MODE_SET && all_idle) begin
                        glob_reg <= SCL_G_MODE_SET;
                        gcnt_reg <= P_MODE_SET_DELAY;
                    end else if (cmd == SCL_REFRESH && all_idle) begin
                        glob_reg <= SCL_G_REFRESH;
                        gcnt_reg <= P_REFRESH_CYCLE;
                    end
                end
                default: begin
                    // timed wait; delay held as a counter
                    if (gcnt_reg <= 8'h01) begin
                        glob_reg <= SCL_G_NORMAL;
                        gcnt_reg <= '0;
                    end else begin
                        gcnt_reg <= gcnt_reg - 8'h01;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // outputs, all registered
    // ------------------------------------------------------------
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_illegal      <= 1'b0;
            o_bank_idle    <= '1;
            o_all_idle     <= 1'b1;
            o_mode_setting <= 1'b0;
            o_refreshing   <= 1'b0;
        end else begin
            // flag only; the device does not promise anything afterwards
            o_illegal      <= glob_bad || (|bad_vec);
            o_bank_idle    <= idle_vec;
            o_all_idle     <= all_idle && glob_reg == SCL_G_NORMAL;
            o_mode_setting <= (glob_reg == SCL_G_MODE_SET);
            o_refreshing   <= (glob_reg == SCL_G_REFRESH);
        end
    end

endmodule

// [verification/scl_legality_props.sv]
// scl_legality_props: port-level assertions for the command legality block.
// assumes one clock i_mclk, async reset i_rst, pins held for one cycle.
`timescale 1ns/1ps
module scl_legality_props
    import scl_pkg::*;
#(
    parameter logic [CNT_W-1:0] P_MODE_SET_DELAY = MODE_SET_DELAY_CYC,
    parameter logic [CNT_W-1:0] P_REFRESH_CYCLE  = REFRESH_CYCLE_TIME_CYC
)
(
    input wire logic                 i_mclk,
    input wire logic                 i_rst,
    input wire logic                 i_cs_n,
    input wire logic                 i_ras_n,
    input wire logic                 i_cas_n,
    input wire logic                 i_we_n,
    input wire logic                 o_illegal,
    input wire logic                 o_all_idle,
    input wire logic                 o_mode_setting,
    input wire logic                 o_refreshing
);
    localparam int RF_MAX = int'(P_REFRESH_CYCLE) + 3;
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    logic [CNT_W-1:0] ms_cnt_reg;
    logic [CNT_W-1:0] rf_cnt_reg;
    wire logic is_mrs  = !i_cs_n && !i_ras_n && !i_cas_n && !i_we_n;
    wire logic is_ref  = !i_cs_n && !i_ras_n && !i_cas_n && i_we_n;
    wire logic is_act  = !i_cs_n && !i_ras_n && i_cas_n && i_we_n;
    wire logic is_col  = !i_cs_n && i_ras_n && !i_cas_n;
    wire logic is_quiet = i_cs_n || (i_ras_n && i_cas_n && i_we_n);
    // length of the current mode-set wait, zero outside it
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) ms_cnt_reg <= 8'h00;
        else if (o_mode_setting) ms_cnt_reg <= ms_cnt_reg + 8'h01;
        else ms_cnt_reg <= 8'h00;
    end
    // length of the current refresh wait, zero outside it
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) rf_cnt_reg <= 8'h00;
        else if (o_refreshing) rf_cnt_reg <= rf_cnt_reg + 8'h01;
        else rf_cnt_reg <= 8'h00;
    end
    // pins sampled at edge n are judged against the state that o_all_idle,
    // o_mode_setting and o_refreshing show at edge n+2; o_illegal answers there
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    AST_MODE_SET_ENTER: assert property (is_mrs ##2 o_all_idle |-> ##1 o_mode_setting)
        else $error("mode set did not start the mode-set wait");
    AST_MODE_SET_LONG: assert property (ms_cnt_reg <= P_MODE_SET_DELAY)
        else $error("mode-set wait outlasted its delay");
    AST_MODE_SET_SHORT: assert property ($fell(o_mode_setting) |-> ms_cnt_reg == P_MODE_SET_DELAY)
        else $error("mode-set wait ended early");
    AST_REF_LONG: assert property (rf_cnt_reg <= P_REFRESH_CYCLE)
        else $error("refresh wait outlasted its delay");
    AST_REF_SHORT: assert property ($fell(o_refreshing) |-> rf_cnt_reg == P_REFRESH_CYCLE)
        else $error("refresh wait ended early");
    AST_REF_SPAN: assert property ($rose(o_refreshing) |-> o_refreshing[*3] ##[1:RF_MAX] !o_refreshing)
        else $error("refresh wait length wrong");
    AST_REF_ENTER: assert property (is_ref ##2 o_all_idle |-> ##1 o_refreshing)
        else $error("refresh did not start the refresh wait");
    AST_MODE_SET_BLOCK: assert property (is_col ##2 o_mode_setting |-> o_illegal)
        else $error("column command during mode set not flagged");
    AST_REF_BLOCK: assert property (is_act ##2 o_refreshing |-> o_illegal)
        else $error("activate during refresh not flagged");
    AST_REF_NEEDS_IDLE: assert property (is_ref ##2 !o_all_idle |-> o_illegal)
        else $error("refresh with busy banks not flagged");
    AST_QUIET_LEGAL: assert property ($past(is_quiet, 2) |-> !o_illegal)
        else $error("deselect or no-op flagged");
    cover property (is_mrs && o_all_idle);
    cover property ($rose(o_refreshing));
    cover property (o_illegal);
endmodule
bind scl_legality scl_legality_props #(.P_MODE_SET_DELAY(P_MODE_SET_DELAY),
    .P_REFRESH_CYCLE(P_REFRESH_CYCLE)) scl_legality_props_inst (.i_mclk(i_mclk),
    .i_rst(i_rst), .i_cs_n(i_cs_n), .i_ras_n(i_ras_n), .i_cas_n(i_cas_n), .i_we_n(i_we_n),
    .o_illegal(o_illegal), .o_all_idle(o_all_idle), .o_mode_setting(o_mode_setting),
    .o_refreshing(o_refreshing));

// [verification/scl_ctrl_model.sv]
// scl_ctrl_model: behavioural controller driving command pins on falling edges.
// assumes callers enter issue just after a falling edge.
`timescale 1ns/1ps
module scl_ctrl_model
    import scl_pkg::*;
(
    input  wire logic              i_mclk,
    output logic                   o_cs_n,
    output logic                   o_ras_n,
    output logic                   o_cas_n,
    output logic                   o_we_n,
    output logic [BANK_W-1:0]      o_bank,
    output logic                   o_a10
);
    initial {o_cs_n, o_ras_n, o_cas_n, o_we_n, o_bank, o_a10} = 7'h40;
    // back to no-operation; the address is don't-care then, so it shows the inverse
    task automatic hold_nop();
        if ({o_cs_n, o_ras_n, o_cas_n, o_we_n} != 4'h7) begin
            o_bank = ~o_bank;
            o_a10 = ~o_a10;
        end
        {o_cs_n, o_ras_n, o_cas_n, o_we_n} = 4'h7;
    endtask
    // one-cycle command, next one spacing cycles later; spacing is the caller's count
    // spacing 1 leaves the pins for the next command, so no pin changes twice at one edge
    task automatic issue(input logic [3:0] c, input logic [BANK_W-1:0] b, input logic a,
                         input int spacing);
        {o_cs_n, o_ras_n, o_cas_n, o_we_n} = c;
        o_bank = b;
        o_a10 = a;
        @(negedge i_mclk);
        if (spacing > 1) begin
            hold_nop();
            repeat (spacing - 1) @(negedge i_mclk);
        end
    endtask
endmodule

// [verification/scl_legality_test.sv]
// scl_legality_test: directed scenarios for the command legality block.
// assumes the controller model and the bound checker are compiled first.
`timescale 1ns/1ps
module scl_legality_test;
    import scl_pkg::*;
    localparam logic [3:0] C_MRS = 4'h0, C_REF = 4'h1, C_PRE = 4'h2, C_ACT = 4'h3;
    localparam logic [3:0] C_WR = 4'h4, C_RD = 4'h5, C_NOP = 4'h7, C_DES = 4'h8;
    logic                 i_mclk = 1'b0;
    logic                 i_rst  = 1'b1;
    logic [CNT_W-1:0]     al     = 8'h00;
    logic                 cs_n, ras_n, cas_n, we_n, a10;
    logic [BANK_W-1:0]    bank;
    logic                 o_illegal, o_all_idle, o_mode_setting, o_refreshing;
    logic [NUM_BANKS-1:0] o_bank_idle;
    int                   n_fail = 0, comparisons = 0, ill_cnt = 0;
    always #12.5 i_mclk = ~i_mclk;
    always @(posedge i_mclk) if (o_illegal === 1'b1) ill_cnt++;
    scl_ctrl_model scl_ctrl_model_inst (.i_mclk(i_mclk), .o_cs_n(cs_n), .o_ras_n(ras_n),
        .o_cas_n(cas_n), .o_we_n(we_n), .o_bank(bank), .o_a10(a10));
    // longer waits than default so mid-wait commands land safely inside them
    scl_legality #(.P_MODE_SET_DELAY(8'h06), .P_REFRESH_CYCLE(8'h08), .P_ACT_TO_COL(8'h03),
        .P_WRITE_TO_READ(8'h03)) scl_legality_inst (.i_mclk(i_mclk), .i_rst(i_rst),
        .i_cs_n(cs_n), .i_ras_n(ras_n), .i_cas_n(cas_n), .i_we_n(we_n), .i_bank(bank),
        .i_a10(a10), .i_additive_latency(al), .o_illegal(o_illegal),
        .o_bank_idle(o_bank_idle), .o_all_idle(o_all_idle),
        .o_mode_setting(o_mode_setting), .o_refreshing(o_refreshing));
    task automatic check(input logic [3:0] got, input logic [3:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR at %0t: got %b expected %b", $time, got, exp);
        end
    endtask
    task automatic check_cnt(input int got, input int exp);
        comparisons++;
        if (got != exp) begin
            n_fail++;
            $display("ERROR at %0t: count %0d expected %0d", $time, got, exp);
        end
    endtask
    task automatic go(input logic [3:0] c, input logic [1:0] b, input logic a, input int s);
        scl_ctrl_model_inst.issue(c, b, a, s);
    endtask
    // flagged commands since the last call, after the pipeline drains
    task automatic exp_ill(input int n);
        scl_ctrl_model_inst.hold_nop();
        repeat (4) @(negedge i_mclk);
        check_cnt(ill_cnt, n);
        ill_cnt = 0;
    endtask
    task automatic wait_idle(input int lim);
        int n;
        n = 0;
        scl_ctrl_model_inst.hold_nop();
        while (o_all_idle !== 1'b1 && n < 40) begin
            @(negedge i_mclk);
            n++;
        end
        check_cnt(int'(n <= lim), 1);
    endtask
    task automatic t_reset();
        check({o_all_idle, o_mode_setting, o_refreshing, o_illegal}, 4'b1000);
        check(o_bank_idle, 4'hF);
    endtask
    task automatic t_mode();
        go(C_MRS, 2'h0, 1'b0, 3);
        check({o_mode_setting, o_all_idle, 2'b00}, 4'b1000);
        go(C_RD, 2'h0, 1'b0, 1);
        go(C_DES, 2'h3, 1'b1, 1);
        go(C_NOP, 2'h1, 1'b0, 1);
        exp_ill(1);
        wait_idle(8);
    endtask
    task automatic t_refresh();
        go(C_REF, 2'h0, 1'b0, 3);
        check({o_refreshing, 3'b000}, 4'b1000);
        go(C_ACT, 2'h1, 1'b0, 1);
        exp_ill(1);
        wait_idle(10);
    endtask
    task automatic t_busy();
        go(C_ACT, 2'h1, 1'b0, 5);
        go(C_REF, 2'h0, 1'b0, 1);
        exp_ill(1);
        go(C_PRE, 2'h0, 1'b1, 1);
        wait_idle(6);
        check(o_bank_idle, 4'hF);
    endtask
    task automatic t_banks();
        al = 8'h00;
        go(C_ACT, 2'h0, 1'b0, 1);
        go(C_RD, 2'h0, 1'b0, 1);
        go(C_ACT, 2'h1, 1'b0, 4);
        exp_ill(1);
        check(o_bank_idle, 4'b1100);
        al = 8'h03;
        go(C_ACT, 2'h2, 1'b0, 1);
        go(C_RD, 2'h2, 1'b0, 6);
        exp_ill(0);
        al = 8'h00;
        go(C_PRE, 2'h0, 1'b1, 1);
        wait_idle(6);
    endtask
    task automatic t_burst();
        go(C_ACT, 2'h3, 1'b0, 5);
        go(C_RD, 2'h3, 1'b0, 4);
        go(C_RD, 2'h3, 1'b0, 2);
        go(C_RD, 2'h3, 1'b0, 8);
        exp_ill(1);
        go(C_WR, 2'h3, 1'b0, 12);
        go(C_RD, 2'h3, 1'b0, 6);
        exp_ill(0);
        // read right behind a write lands inside write recovery: flagged
        go(C_WR, 2'h3, 1'b0, 1);
        go(C_RD, 2'h3, 1'b0, 1);
        exp_ill(1);
        go(C_PRE, 2'h0, 1'b1, 1);
        wait_idle(6);
    endtask
    task automatic results();
        $display("comparisons %0d, n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // whole run is well under 400 cycles
    initial begin
        #(25 * 4000);
        n_fail++;
        results();
    end
    initial begin
        repeat (8) @(negedge i_mclk);
        i_rst = 1'b0;
        @(negedge i_mclk);
        t_reset();
        t_mode();
        t_refresh();
        t_busy();
        t_banks();
        t_burst();
        results();
    end
endmodule
